// [inc/nap_pkg.sv]
// package for the nonvolatile memory access protection block
package nap_pkg;
    localparam int PADDR_W = 15;
    localparam int PDATA_W = 14;
    localparam int EADDR_W = 8;
    localparam int EDATA_W = 8;
    // program array depth: 16K words
    localparam int PDEPTH  = 16384;
    localparam int EDEPTH  = 256;
    localparam int UID_N   = 4;
    // user id window 8000h..8003h
    localparam logic [PADDR_W-1:0] UID_BASE = 15'h0000;
    localparam logic [15:0]        UID_ADDR = 16'h8000;
    // self-write protect size codes
    localparam logic [1:0] WP_HALF    = 2'h0;
    localparam logic [1:0] WP_QUARTER = 2'h1;
    localparam logic [1:0] WP_BOOT    = 2'h2;
    localparam logic [1:0] WP_OFF     = 2'h3;
    // protected block upper bounds (exclusive) per code
    localparam logic [14:0] WP_HALF_END    = 15'h2000;
    localparam logic [14:0] WP_QUARTER_END = 15'h1000;
    localparam logic [14:0] WP_BOOT_END    = 15'h0200;
    localparam logic [PDATA_W-1:0] PDATA_ZERO = 14'h0000;
    localparam logic [EDATA_W-1:0] EDATA_ZERO = 8'h00;

    typedef enum logic [1:0] {
        NAP_SRC_NONE = 2'b00,
        NAP_SRC_CPU  = 2'b01,
        NAP_SRC_EXT  = 2'b10
    } nap_src_t;

    // one memory request; addr 8000h..8003h selects configuration space (user id)
    typedef struct packed {
        logic        valid;
        logic        we;
        logic        eeprom;
        logic [15:0] addr;
        logic [13:0] wdata;
    } nap_req_t;

    typedef struct packed {
        logic        valid;
        logic        refused;
        logic [13:0] rdata;
    } nap_rsp_t;
endpackage : nap_pkg

// [logic/nap_mem.sv]
// single port memory with registered read data
`timescale 1ns/1ps
module nap_mem
    import nap_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // read first in array, read data registered
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : nap_mem

// [logic/nap_protect.sv]
// access protection for program flash and data eeprom
// Functional notes
// - program protect 0: external program access refused, reads zero; user id words stay open
// - cpu always reads program memory
// - cpu program write depends only on size
// - eeprom protect 0: external eeprom access blocked
// - cpu always reads and writes eeprom
// - each protection uses only its bit
// - two-bit field sets protected block size
// - four user id words, run-time read/write
`timescale 1ns/1ps
module nap_protect
    import nap_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                program_read_protect_n_i,
    input  wire logic                eeprom_read_protect_n_i,
    input  wire logic [1:0]          self_write_protect_size_i,
    input  wire nap_req_t            cpu_req_i,
    input  wire nap_req_t            ext_req_i,
    output nap_rsp_t                 cpu_rsp_o,
    output nap_rsp_t                 ext_rsp_o,
    output logic                     cpu_busy_o
);
    // configuration bits are strap levels from outside: two flops each
    logic [3:0] cfg_s1_q;
    logic [3:0] cfg_s2_q;
    logic [3:0] cfg_s1_d;
    logic [3:0] cfg_s2_d;
    logic       prog_protect_n;
    logic       ee_protect_n;
    logic [1:0] wp_size;

    always_comb begin
        cfg_s1_d = {program_read_protect_n_i, eeprom_read_protect_n_i,
                    self_write_protect_size_i};
        cfg_s2_d = cfg_s1_q;
    end

    // reset to fully protected until straps settle
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cfg_s1_q <= 4'h0;
            cfg_s2_q <= 4'h0;
        end else begin
            cfg_s1_q <= cfg_s1_d;
            cfg_s2_q <= cfg_s2_d;
        end
    end

    assign prog_protect_n = cfg_s2_q[3];
    assign ee_protect_n   = cfg_s2_q[2];
    assign wp_size        = cfg_s2_q[1:0];

    // true when a program word falls in the shielded block
    function automatic logic in_wp_block(input logic [1:0] sz, input logic [14:0] a);
        unique case (sz)
            WP_HALF:    in_wp_block = (a < WP_HALF_END);
            WP_QUARTER: in_wp_block = (a < WP_QUARTER_END);
            WP_BOOT:    in_wp_block = (a < WP_BOOT_END);
            WP_OFF:     in_wp_block = 1'b0;
        endcase
    endfunction : in_wp_block

    // true when the address hits the user id words
    function automatic logic is_uid(input logic [15:0] a);
        is_uid = (a[15:2] == UID_ADDR[15:2]);
    endfunction : is_uid

    // arbitration: cpu wins, external loses; memories are single port
    // a losing external request is dropped, not queued, so the programmer must retry
    nap_src_t   grant;
    nap_req_t   req;
    logic       refuse;
    logic       prog_we;
    logic       ee_we;
    logic       uid_we;

    always_comb begin
        grant = NAP_SRC_NONE;
        req   = '0;
        if (cpu_req_i.valid) begin
            grant = NAP_SRC_CPU;
            req   = cpu_req_i;
        end else if (ext_req_i.valid) begin
            grant = NAP_SRC_EXT;
            req   = ext_req_i;
        end
        refuse  = 1'b0;
        prog_we = 1'b0;
        ee_we   = 1'b0;
        uid_we  = 1'b0;
        if (grant == NAP_SRC_EXT) begin
            refuse = req.eeprom ? !ee_protect_n : (!prog_protect_n && !is_uid(req.addr));
        end
        if (req.valid && req.we && !refuse) begin
            if (req.eeprom) begin
                ee_we = 1'b1;
            end else if (is_uid(req.addr)) begin
                uid_we = 1'b1;
            end else if (grant == NAP_SRC_CPU) begin
                prog_we = !in_wp_block(wp_size, req.addr[14:0]);
            end else begin
                prog_we = 1'b1;
            end
        end
    end

    logic [PDATA_W-1:0] prog_rdata;
    logic [EDATA_W-1:0] ee_rdata;

    nap_mem #(.AW(14), .DW(PDATA_W)) u_prog (
        .clk_i   (clk_i),
        .we_i    (prog_we),
        .addr_i  (req.addr[13:0]),
        .wdata_i (req.wdata),
        .rdata_o (prog_rdata)
    );

    nap_mem #(.AW(EADDR_W), .DW(EDATA_W)) u_ee (
        .clk_i   (clk_i),
        .we_i    (ee_we),
        .addr_i  (req.addr[EADDR_W-1:0]),
        .wdata_i (req.wdata[EDATA_W-1:0]),
        .rdata_o (ee_rdata)
    );

    // user id words are few enough for flops
    logic [PDATA_W-1:0] uid_q [UID_N];
    logic [PDATA_W-1:0] uid_d [UID_N];

    // next id words: a granted write replaces one word
    always_comb begin
        for (int i = 0; i < UID_N; i++) begin
            uid_d[i] = uid_q[i];
        end
        if (uid_we) begin
            uid_d[req.addr[1:0]] = req.wdata;
        end
    end

    // ids clear on reset, unlike the arrays, so a fresh part reads zero ids
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < UID_N; i++) begin
                uid_q[i] <= PDATA_ZERO;
            end
        end else begin
            for (int i = 0; i < UID_N; i++) begin
                uid_q[i] <= uid_d[i];
            end
        end
    end

    // stage one cycle so response lines up with registered memory data
    nap_src_t   grant_q;
    logic       refuse_q;
    logic       sel_ee_q;
    logic       sel_uid_q;
    logic [1:0] uid_idx_q;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            grant_q   <= NAP_SRC_NONE;
            refuse_q  <= 1'b0;
            sel_ee_q  <= 1'b0;
            sel_uid_q <= 1'b0;
            uid_idx_q <= 2'h0;
        end else begin
            grant_q   <= grant;
            refuse_q  <= refuse;
            sel_ee_q  <= req.eeprom;
            sel_uid_q <= !req.eeprom && is_uid(req.addr);
            uid_idx_q <= req.addr[1:0];
        end
    end

    logic [PDATA_W-1:0] rd_mux;
    // read data select; a refused read never shows array contents
    always_comb begin
        if (refuse_q) begin
            rd_mux = PDATA_ZERO;
        end else if (sel_ee_q) begin
            rd_mux = {6'h00, ee_rdata};
        end else if (sel_uid_q) begin
            rd_mux = uid_q[uid_idx_q];
        end else begin
            rd_mux = prog_rdata;
        end
    end

    // outputs registered; response two cycles after request
    nap_rsp_t cpu_rsp_q;
    nap_rsp_t ext_rsp_q;
    logic     busy_q;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cpu_rsp_q <= '0;
            ext_rsp_q <= '0;
            busy_q    <= 1'b0;
        end else begin
            cpu_rsp_q <= '{valid: grant_q == NAP_SRC_CPU, refused: 1'b0,
                           rdata: rd_mux};
            ext_rsp_q <= '{valid: grant_q == NAP_SRC_EXT, refused: refuse_q,
                           rdata: rd_mux};
            busy_q    <= cpu_req_i.valid;
        end
    end

    assign cpu_rsp_o  = cpu_rsp_q;
    assign ext_rsp_o  = ext_rsp_q;
    assign cpu_busy_o = busy_q;
endmodule : nap_protect

// [sim/nap_protect_checker.sv]
// port-level assertions for the access protection block
`timescale 1ns/1ps
module nap_protect_checker
    import nap_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    input wire logic       program_read_protect_n_i,
    input wire logic       eeprom_read_protect_n_i,
    input wire logic [1:0] self_write_protect_size_i,
    input wire nap_req_t   cpu_req_i,
    input wire nap_req_t   ext_req_i,
    input wire nap_rsp_t   cpu_rsp_o,
    input wire nap_rsp_t   ext_rsp_o,
    input wire logic       cpu_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // an external request survives only when the cpu is idle
    logic xv;
    logic xu;
    assign xv = ext_req_i.valid & ~cpu_req_i.valid;
    // xu marks only the four user id words, other high addresses stay protected
    assign xu = (ext_req_i.addr[15:2] == UID_ADDR[15:2]) & ~ext_req_i.eeprom;
    prot_zero_a: assert property ((!program_read_protect_n_i)[*4] ##0 xv && !xu
        && !ext_req_i.eeprom |-> ##2 ext_rsp_o.refused && ext_rsp_o.rdata == 14'h0)
        else $error("protected program access not refused");
    ee_block_a: assert property ((!eeprom_read_protect_n_i)[*4] ##0 xv && ext_req_i.eeprom
        |-> ##2 ext_rsp_o.valid && ext_rsp_o.refused) else $error("eeprom access not blocked");
    cpu_open_a: assert property (cpu_req_i.valid |-> ##2 cpu_rsp_o.valid
        && !cpu_rsp_o.refused) else $error("cpu access refused");
    ee_width_a: assert property (cpu_req_i.valid && cpu_req_i.eeprom |-> ##2
        cpu_rsp_o.rdata[13:8] == 6'h0) else $error("eeprom data too wide");
    uid_open_a: assert property (xv && xu |-> ##2 ext_rsp_o.valid
        && !ext_rsp_o.refused) else $error("user id refused");
    prog_open_a: assert property ((program_read_protect_n_i && reset_n_i)[*4] ##0 xv
        && !ext_req_i.eeprom |-> ##2 !ext_rsp_o.refused) else $error("open program refused");
    ee_open_a: assert property ((eeprom_read_protect_n_i && reset_n_i)[*4] ##0 xv
        && ext_req_i.eeprom |-> ##2 !ext_rsp_o.refused) else $error("open eeprom refused");
    ext_lat_a: assert property (!xv |-> ##2 !ext_rsp_o.valid)
        else $error("spurious external answer");
    busy_flag_a: assert property (cpu_busy_o == $past(cpu_req_i.valid))
        else $error("busy flag does not follow cpu request");
endmodule : nap_protect_checker

bind nap_protect nap_protect_checker nap_protect_checker_i (.*);

// [sim/nap_ext_prog.sv]
// behavioural external programmer on the programming side
`timescale 1ns/1ps
module nap_ext_prog
    import nap_pkg::*;
(
    input  wire logic     clk_i,
    input  wire nap_rsp_t rsp_i,
    output nap_req_t      req_o
);
    nap_rsp_t rsp;
    initial req_o = '0;
    // one-cycle request, lines scrambled once released so stale values never pass
    task automatic access(input logic w, e, input logic [15:0] a, input logic [13:0] d);
        @(negedge clk_i) req_o <= '{1'b1, w, e, a, d};
        @(negedge clk_i) req_o <= '{1'b0, ~w, ~e, ~a, ~d};
        // the answer stands only in the cycle after the edge that follows the taking edge
        @(negedge clk_i) rsp = rsp_i;
    endtask : access
endmodule : nap_ext_prog

// [sim/nvm_access_protection_bench.sv]
// self-checking bench for the access protection block
`timescale 1ns/1ps
module nvm_access_protection_bench
    import nap_pkg::*;
;
    logic clk_i = 0, reset_n_i = 0, pn = 1, en = 1;
    logic [1:0] ws = WP_OFF;
    nap_req_t cpu_req_i = '0, ext_req_i;
    nap_rsp_t cpu_rsp_o, ext_rsp_o, cr;
    int miscompares = 0, comparisons = 0;
    logic [14:0] ends [4] = '{15'h2000, 15'h1000, 15'h0200, 15'h0};
    always #20 clk_i = ~clk_i;
    nap_protect nap_protect_i (.clk_i, .reset_n_i, .program_read_protect_n_i(pn),
        .eeprom_read_protect_n_i(en), .self_write_protect_size_i(ws), .cpu_req_i,
        .ext_req_i, .cpu_rsp_o, .ext_rsp_o, .cpu_busy_o());
    nap_ext_prog nap_ext_prog_i (.clk_i, .rsp_i(ext_rsp_o), .req_o(ext_req_i));
    task automatic chk(input logic [14:0] g, e);
        comparisons++;
        if (g !== e || cr.valid !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: got %h/%b expected %h", $time, g, cr.valid, e);
        end
    endtask : chk
    // config straps need a few edges to settle
    task automatic cfg(input logic p, e, input logic [1:0] s);
        @(negedge clk_i) {pn, en, ws} <= {p, e, s};
        repeat (4) @(negedge clk_i);
    endtask : cfg
    task automatic cop(input logic w, e, input logic [15:0] a, input logic [13:0] d);
        @(negedge clk_i) cpu_req_i <= '{1'b1, w, e, a, d};
        @(negedge clk_i) cpu_req_i <= '{1'b0, ~w, ~e, ~a, ~d};
        // answer stands for one cycle only, take it mid-cycle
        @(negedge clk_i) cr = cpu_rsp_o;
    endtask : cop
    task automatic xop(input logic w, e, input logic [15:0] a, input logic [13:0] d);
        nap_ext_prog_i.access(w, e, a, d);
        cr = nap_ext_prog_i.rsp;
    endtask : xop
    // program array locked from outside, still readable inside
    task automatic t_prog();
        cfg(1, 1, WP_OFF);
        xop(1, 0, 16'h0010, 14'h2abc);
        xop(1, 1, 16'h0005, 14'h00c3);
        cfg(0, 1, WP_OFF);
        xop(1, 0, 16'h0010, 14'h1234);
        xop(0, 0, 16'h0010, 14'h0);
        chk({cr.refused, cr.rdata}, 15'h4000);
        cop(0, 0, 16'h0010, 14'h0);
        chk({cr.refused, cr.rdata}, 15'h2abc);
        xop(0, 1, 16'h0005, 14'h0);
        chk({cr.refused, cr.rdata}, 15'h00c3);
    endtask : t_prog
    // eeprom locked from outside only
    task automatic t_ee();
        cfg(1, 0, WP_OFF);
        cop(1, 1, 16'h0033, 14'h005a);
        cop(0, 1, 16'h0033, 14'h0);
        chk({cr.refused, cr.rdata}, 15'h005a);
        xop(1, 1, 16'h0033, 14'h0011);
        xop(0, 1, 16'h0033, 14'h0);
        chk({cr.refused, cr.rdata}, 15'h4000);
        cop(0, 1, 16'h0033, 14'h0);
        chk({cr.refused, cr.rdata}, 15'h005a);
        xop(0, 0, 16'h0010, 14'h0);
        chk({cr.refused, cr.rdata}, 15'h2abc);
    endtask : t_ee
    // each size code: last word inside the block and first outside
    task automatic t_wp();
        logic [15:0] a;
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 2; k++) begin
                a = {2'b0, 14'(ends[c] - 15'(1 - k))};
                cfg(1, 1, WP_OFF);
                xop(1, 0, a, 14'h0155);
                cfg(c[0], 1, 2'(c));
                cop(1, 0, a, 14'h2aaa);
                cop(0, 0, a, 14'h0);
                chk({cr.refused, cr.rdata}, (k == 0 && c != 3) ? 15'h0155 : 15'h2aaa);
            end
        end
    endtask : t_wp
    // user id words stay open with the array locked
    task automatic t_uid();
        cfg(0, 0, WP_HALF);
        xop(1, 0, 16'h8003, 14'h0bcd);
        xop(0, 0, 16'h8003, 14'h0);
        chk({cr.refused, cr.rdata}, 15'h0bcd);
        cop(1, 0, 16'h8000, 14'h0777);
        cop(0, 0, 16'h8000, 14'h0);
        chk({cr.refused, cr.rdata}, 15'h0777);
    endtask : t_uid
    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(negedge clk_i);
        reset_n_i <= 1;
        t_prog();
        t_ee();
        t_wp();
        t_uid();
        wrap_up();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #(40 * 3000);
        miscompares++;
        wrap_up();
    end
endmodule : nvm_access_protection_bench
